// ---- verilog/bst_port.sv ----
// Boundary-scan test access port with controller, instruction and data registers
`timescale 1ns/1ns
module bst_port #(
  parameter int NUM_IOB = 8
) (
  // System side
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             cfg_busy,
  input  wire logic             scan_enable_symbol,
  output logic                  port_active_r,
  // Test link
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  output logic                  tdo_r,
  output logic                  tdo_oe_r,
  // Pads, top bit is the output-only mode pin
  input  wire logic [NUM_IOB:0] pad_in,
  input  wire logic             mode_pin_zero,
  input  wire logic             mode_pin_two,
  output logic      [NUM_IOB:0] pad_out_r,
  output logic      [NUM_IOB:0] pad_oe_r,
  // Core logic
  input  wire logic [NUM_IOB:0] core_out,
  input  wire logic [NUM_IOB:0] core_oe,
  input  wire logic             int_ts_in,
  input  wire logic             int_out_in,
  output logic                  update_internal_cell,
  // User chains and configuration paths
  input  wire logic             user_chain_one_out,
  input  wire logic             user_chain_two_out,
  input  wire logic             readback_data,
  input  wire logic             cfg_dout,
  output logic                  user_sel_one_r,
  output logic                  user_sel_two_r,
  output logic                  readback_sel_r,
  output logic                  cfg_sel_r,
  output logic                  dr_capture_r,
  output logic                  dr_shift_r,
  output logic                  dr_update_r
);

  localparam int NP = NUM_IOB + 1;
  localparam int MB = bst_pkg::CELL_IOB0 + bst_pkg::CELLS_IOB * NP;
  localparam int BL = MB + 3;
  localparam int CW = 3 * NP + 4;
  localparam int XW = 2 * NP + 2;

  bst_pkg::bst_tap_t           st_r;
  bst_pkg::bst_tap_t           st_nxt;
  logic [1:0]                  rst_t;
  logic [1:0]                  act_t;
  logic [CW-1:0]               cap1_r;
  logic [CW-1:0]               cap2_r;
  logic [bst_pkg::IR_W-1:0]    ir_sh_r;
  logic [bst_pkg::IR_W-1:0]    ir_r;
  logic                        byp_r;
  logic [BL-1:0]               bsr_r;
  logic [BL-1:0]               upd_r;
  logic [BL-1:0]               cap_vec;
  logic                        bsr_sel;
  logic                        tap_rst;
  logic                        tdo_src;
  logic                        mode_ext_r;
  logic                        mode_cfg_r;
  logic [XW-1:0]               xs1_r;
  logic [XW-1:0]               xs2_r;
  logic [XW-1:0]               xs3_r;
  logic [XW-1:0]               xvec;

  // ------------------------------------------------------------
  // Controller
  // ------------------------------------------------------------
  function automatic bst_pkg::bst_tap_t tap_step(input bst_pkg::bst_tap_t s,
                                                 input logic m);
    case (s)
      bst_pkg::ST_TLR: tap_step = m ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI: tap_step = m ? bst_pkg::ST_SDS : bst_pkg::ST_RTI;
      bst_pkg::ST_SDS: tap_step = m ? bst_pkg::ST_SIS : bst_pkg::ST_CDR;
      bst_pkg::ST_CDR: tap_step = m ? bst_pkg::ST_E1D : bst_pkg::ST_SDR;
      bst_pkg::ST_SDR: tap_step = m ? bst_pkg::ST_E1D : bst_pkg::ST_SDR;
      bst_pkg::ST_E1D: tap_step = m ? bst_pkg::ST_UDR : bst_pkg::ST_PDR;
      bst_pkg::ST_PDR: tap_step = m ? bst_pkg::ST_E2D : bst_pkg::ST_PDR;
      bst_pkg::ST_E2D: tap_step = m ? bst_pkg::ST_UDR : bst_pkg::ST_SDR;
      bst_pkg::ST_UDR: tap_step = m ? bst_pkg::ST_SDS : bst_pkg::ST_RTI;
      bst_pkg::ST_SIS: tap_step = m ? bst_pkg::ST_TLR : bst_pkg::ST_CIR;
      bst_pkg::ST_CIR: tap_step = m ? bst_pkg::ST_E1I : bst_pkg::ST_SIR;
      bst_pkg::ST_SIR: tap_step = m ? bst_pkg::ST_E1I : bst_pkg::ST_SIR;
      bst_pkg::ST_E1I: tap_step = m ? bst_pkg::ST_UIR : bst_pkg::ST_PIR;
      bst_pkg::ST_PIR: tap_step = m ? bst_pkg::ST_E2I : bst_pkg::ST_PIR;
      bst_pkg::ST_E2I: tap_step = m ? bst_pkg::ST_UIR : bst_pkg::ST_SIR;
      default:         tap_step = m ? bst_pkg::ST_SDS : bst_pkg::ST_RTI;
    endcase
  endfunction : tap_step

  // Power-on reset and port activity reach the link side as levels
  always_ff @(posedge tck) begin
    rst_t <= {rst_t[0], rst_n};
    act_t <= {act_t[0], port_active_r};
  end
  assign tap_rst = !rst_t[1] || !act_t[1];
  assign st_nxt  = tap_step(st_r, tms);
  always_ff @(posedge tck) begin
    if (tap_rst) begin
      st_r <= bst_pkg::ST_TLR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Instruction register
  // ------------------------------------------------------------
  always_ff @(posedge tck) begin
    if (tap_rst || st_r == bst_pkg::ST_CIR) begin
      ir_sh_r <= bst_pkg::IR_CAPT;
    end else if (st_r == bst_pkg::ST_SIR) begin
      ir_sh_r <= {tdi, ir_sh_r[bst_pkg::IR_W-1:1]};
    end
  end

  always_ff @(negedge tck) begin
    if (st_r == bst_pkg::ST_TLR) begin
      ir_r <= bst_pkg::IR_RST;
    end else if (st_r == bst_pkg::ST_UIR) begin
      ir_r <= (ir_sh_r == bst_pkg::IR_RSVD) ? bst_pkg::IR_BYPASS : ir_sh_r;
    end
  end

  // ------------------------------------------------------------
  // Bypass and boundary data registers
  // ------------------------------------------------------------
  always_ff @(posedge tck) begin
    if (tap_rst || st_r == bst_pkg::ST_CDR) begin
      byp_r <= bst_pkg::BYP_CAPT;
    end else if (st_r == bst_pkg::ST_SDR) begin
      byp_r <= tdi;
    end
  end

  // Pad and core levels are foreign to the link clock
  always_ff @(posedge tck) begin
    cap1_r <= {int_out_in, int_ts_in, mode_pin_two, mode_pin_zero, core_oe, core_out, pad_in};
    cap2_r <= cap1_r;
  end

  assign cap_vec[bst_pkg::CELL_INT_TS]  = cap2_r[3*NP+2];
  assign cap_vec[bst_pkg::CELL_INT_OUT] = cap2_r[3*NP+3];
  assign cap_vec[MB]                    = cap2_r[3*NP];
  assign cap_vec[MB+1]                  = cap2_r[3*NP+1];
  assign cap_vec[MB+2]                  = upd_r[BL-1];

  genvar gk;
  generate
    for (gk = 0; gk < NP; gk++) begin : g_cell
      localparam int B = bst_pkg::CELL_IOB0 + bst_pkg::CELLS_IOB * gk;
      assign cap_vec[B+bst_pkg::CELL_IN]  = cap2_r[gk];
      assign cap_vec[B+bst_pkg::CELL_OUT] = cap2_r[NP+gk];
      assign cap_vec[B+bst_pkg::CELL_TS]  = cap2_r[2*NP+gk];
      assign xvec[gk]                     = upd_r[B+bst_pkg::CELL_OUT];
      assign xvec[NP+gk]                  = upd_r[B+bst_pkg::CELL_TS];
    end
  endgenerate
  assign bsr_sel = (ir_r == bst_pkg::IR_EXTEST) || (ir_r == bst_pkg::IR_SAMPLE);
  always_ff @(posedge tck) begin
    if (st_r == bst_pkg::ST_CDR && bsr_sel) begin
      bsr_r <= cap_vec;
    end else if (st_r == bst_pkg::ST_SDR && bsr_sel) begin
      bsr_r <= {tdi, bsr_r[BL-1:1]};
    end
  end

  always_ff @(negedge tck) begin
    if (tap_rst) begin
      upd_r <= '0;
    end else if (st_r == bst_pkg::ST_UDR && bsr_sel) begin
      upd_r <= bsr_r;
    end
  end
  assign update_internal_cell = upd_r[BL-1];

  // ------------------------------------------------------------
  // Test data output
  // ------------------------------------------------------------
  always_comb begin
    if (st_r == bst_pkg::ST_SIR) begin
      tdo_src = ir_sh_r[0];
    end else begin
      case (ir_r)
        bst_pkg::IR_EXTEST, bst_pkg::IR_SAMPLE: tdo_src = bsr_r[0];
        bst_pkg::IR_USER1:                     tdo_src = user_chain_one_out;
        bst_pkg::IR_USER2:                     tdo_src = user_chain_two_out;
        bst_pkg::IR_RDBK:                      tdo_src = readback_data;
        bst_pkg::IR_CFG:                       tdo_src = cfg_dout;
        default:                               tdo_src = byp_r;
      endcase
    end
  end
  always_ff @(negedge tck) begin
    if (tap_rst) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r    <= tdo_src;
      tdo_oe_r <= (st_r == bst_pkg::ST_SIR) || (st_r == bst_pkg::ST_SDR);
    end
  end

  // ------------------------------------------------------------
  // Strobes and selects toward user chains
  // ------------------------------------------------------------
  always_ff @(posedge tck) begin
    if (tap_rst) begin
      user_sel_one_r <= 1'b0;
      user_sel_two_r <= 1'b0;
      readback_sel_r <= 1'b0;
      cfg_sel_r      <= 1'b0;
      dr_capture_r   <= 1'b0;
      dr_shift_r     <= 1'b0;
      dr_update_r    <= 1'b0;
      mode_ext_r     <= 1'b0;
      mode_cfg_r     <= 1'b0;
    end else begin
      user_sel_one_r <= ir_r == bst_pkg::IR_USER1;
      user_sel_two_r <= ir_r == bst_pkg::IR_USER2;
      readback_sel_r <= ir_r == bst_pkg::IR_RDBK;
      cfg_sel_r      <= ir_r == bst_pkg::IR_CFG;
      dr_capture_r   <= st_nxt == bst_pkg::ST_CDR;
      dr_shift_r     <= st_nxt == bst_pkg::ST_SDR;
      dr_update_r    <= st_nxt == bst_pkg::ST_UDR;
      mode_ext_r     <= ir_r == bst_pkg::IR_EXTEST;
      mode_cfg_r     <= ir_r == bst_pkg::IR_CFG;
    end
  end

  // ------------------------------------------------------------
  // System side: activity and pad drive
  // ------------------------------------------------------------
  assign xvec[XW-2] = mode_ext_r;
  assign xvec[XW-1] = mode_cfg_r;
  // The word is applied only once two successive synced samples agree
  always_ff @(posedge sys_clk) begin
    xs1_r <= xvec;
    xs2_r <= xs1_r;
    xs3_r <= xs2_r;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_active_r <= 1'b0;
    end else begin
      port_active_r <= cfg_busy || scan_enable_symbol;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pad_out_r <= '0;
      pad_oe_r  <= '0;
    end else if (xs2_r != xs3_r) begin
      pad_out_r <= pad_out_r;
      pad_oe_r  <= pad_oe_r;
    end else if (xs2_r[XW-1]) begin
      pad_out_r <= '0;
      pad_oe_r  <= '0;
    end else if (xs2_r[XW-2]) begin
      pad_out_r <= xs2_r[NP-1:0];
      pad_oe_r  <= xs2_r[2*NP-1:NP];
    end else begin
      pad_out_r <= core_out;
      pad_oe_r  <= core_oe;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_tms_high;
    tms [*5];
  endsequence
  sequence s_ir_load;
    st_r == bst_pkg::ST_UIR && ir_sh_r == bst_pkg::IR_RSVD;
  endsequence
  a_tms_reset: assert property (
    @(posedge tck) disable iff (tap_rst) s_tms_high |=> st_r == bst_pkg::ST_TLR)
    else $error("five high mode-select bits did not reach reset state");
  a_ir_reset: assert property (
    @(posedge tck) disable iff (tap_rst) st_r == bst_pkg::ST_TLR |=> ir_r == bst_pkg::IR_RST)
    else $error("instruction not bypass after reset state");
  a_rsvd_bypass: assert property (
    @(posedge tck) disable iff (tap_rst) s_ir_load |=> ir_r == bst_pkg::IR_BYPASS)
    else $error("reserved code not taken as bypass");
  a_ir_capture: assert property (
    @(posedge tck) disable iff (tap_rst)
    st_r == bst_pkg::ST_CIR ##1 st_r == bst_pkg::ST_SIR |-> ir_sh_r == bst_pkg::IR_CAPT)
    else $error("instruction capture value wrong");
  a_bypass_zero: assert property (
    @(posedge tck) disable iff (tap_rst) st_r == bst_pkg::ST_CDR |=> byp_r == 1'b0)
    else $error("bypass cell did not capture zero");
  a_tdo_enable: assert property (
    @(posedge tck) disable iff (tap_rst)
    $past(st_r) != st_r |-> tdo_oe_r == (st_r inside {bst_pkg::ST_SIR, bst_pkg::ST_SDR}))
    else $error("output enable outside shift states");
  a_tdo_bsr: assert property (
    @(posedge tck) disable iff (tap_rst)
    st_r == bst_pkg::ST_SDR && bsr_sel && $stable(bsr_r[0]) |-> tdo_r == bsr_r[0])
    else $error("test output not from boundary register");
  a_cell_order: assert property (
    @(posedge tck) disable iff (tap_rst) st_r == bst_pkg::ST_CDR && bsr_sel |=>
    bsr_r[0] == $past(cap2_r[3*NP+2]) && bsr_r[MB+1] == $past(cap2_r[3*NP+1])
    && bsr_r[bst_pkg::CELL_IOB0] == $past(cap2_r[0]))
    else $error("boundary cell order wrong");
  a_cfg_pads: assert property (
    @(posedge sys_clk) disable iff (!rst_n) xs2_r[XW-1] && xs2_r == xs3_r |=> pad_oe_r == '0)
    else $error("pads driven during configure");
  a_ext_pads: assert property (
    @(posedge sys_clk) disable iff (!rst_n) xs2_r[XW-2] && !xs2_r[XW-1] && xs2_r == xs3_r |=>
    pad_out_r == $past(xs2_r[NP-1:0]) && pad_oe_r == $past(xs2_r[2*NP-1:NP]))
    else $error("pads not from update cells in external test");

endmodule : bst_port

// ---- include/bst_pkg.sv ----
// Constants and types shared by the boundary-scan test port
package bst_pkg;

  // ------------------------------------------------------------
  // Controller states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR = 4'b0000, ST_RTI = 4'b0001, ST_SDS = 4'b0010, ST_CDR = 4'b0011,
    ST_SDR = 4'b0100, ST_E1D = 4'b0101, ST_PDR = 4'b0110, ST_E2D = 4'b0111,
    ST_UDR = 4'b1000, ST_SIS = 4'b1001, ST_CIR = 4'b1010, ST_SIR = 4'b1011,
    ST_E1I = 4'b1100, ST_PIR = 4'b1101, ST_E2I = 4'b1110, ST_UIR = 4'b1111
  } bst_tap_t;

  // ------------------------------------------------------------
  // Instruction codes
  // ------------------------------------------------------------
  localparam int         IR_W      = 3;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_SAMPLE = 3'h1;
  localparam logic [2:0] IR_USER1  = 3'h2;
  localparam logic [2:0] IR_USER2  = 3'h3;
  localparam logic [2:0] IR_RDBK   = 3'h4;
  localparam logic [2:0] IR_CFG    = 3'h5;
  localparam logic [2:0] IR_RSVD   = 3'h6;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPT   = 3'h1;
  localparam logic [2:0] IR_RST    = 3'h7;

  // ------------------------------------------------------------
  // Data register layout, counted from the output end
  // ------------------------------------------------------------
  localparam logic BYP_CAPT     = 1'b0;
  localparam int   CELL_INT_TS  = 0;
  localparam int   CELL_INT_OUT = 1;
  localparam int   CELL_IOB0    = 2;
  localparam int   CELLS_IOB    = 3;
  localparam int   CELL_IN      = 0;
  localparam int   CELL_OUT     = 1;
  localparam int   CELL_TS      = 2;

endpackage : bst_pkg

// ---- dv/bst_tester.sv ----
// Behavioural model of the external test controller driving the link
`timescale 1ns/1ns
module bst_tester (
  // Link to the test port
  output logic        tck,
  output logic        tms,
  output logic        tdi,
  input  wire logic   tdo,
  input  wire logic   tdo_oe
);
  localparam int HALF = 3;
  logic [31:0] shifted;
  logic        oe_last;
  logic        oe_seen;

  // Link clock only moves inside a frame
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    shifted = '0;
    oe_last = 1'b0;
    oe_seen = 1'b0;
  end

  // One link cycle; tdo is taken at the rising edge
  task automatic tick(input logic ms, input logic di, output logic seen);
    tms = ms;
    tdi = di;
    #HALF;
    seen = tdo;
    oe_last = tdo_oe;
    tck = 1'b1;
    #HALF;
    tck = 1'b0;
  endtask : tick

  // Mode-select held high while other pins wiggle
  task automatic idle(input int n);
    logic s;
    for (int i = 0; i < n; i++) tick(1'b1, ~tdi, s);
  endtask : idle

  // From idle or reset into Shift-IR, three bits, back to idle
  task automatic load_ir(input logic [2:0] code);
    logic s;
    tick(1'b0, 1'b0, s);
    tick(1'b1, 1'b0, s);
    tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
    tick(1'b0, 1'b0, s);
    for (int i = 0; i < 3; i++) tick(i == 2, code[i], shifted[i]);
    tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask : load_ir

  // Capture, shift n bits least significant first, update, back to idle
  task automatic scan_dr(input logic [31:0] din, input int n);
    logic s;
    tick(1'b0, 1'b0, s);
    tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
    tick(1'b0, 1'b0, s);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], shifted[i]);
      if (i == 0) oe_seen = oe_last;
    end
    tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask : scan_dr
endmodule : bst_tester

// ---- dv/testbench.sv ----
// Self-checking testbench for the boundary-scan test port
`timescale 1ns/1ns
module testbench;
  localparam int          NIOB    = 8;
  localparam int          BSR_LEN = 3 * (NIOB + 1) + 5;
  localparam logic [31:0] PAT     = 32'h5a3c_96e1;
  typedef struct packed {
    logic [2:0] ir;
    logic [4:0] src;
    logic       bit0;
    logic [3:0] sel;
    logic [1:0] pads;
  } bst_row_t;
  logic sys_clk, rst_n, cfg_busy, scan_enable_symbol, port_active_r;
  logic tck, tms, tdi, tdo_r, tdo_oe_r, tdo_line, update_internal_cell;
  logic mode_pin_zero, mode_pin_two, int_ts_in, int_out_in;
  logic user_chain_one_out, user_chain_two_out, readback_data, cfg_dout;
  logic user_sel_one_r, user_sel_two_r, readback_sel_r, cfg_sel_r;
  logic dr_capture_r, dr_shift_r, dr_update_r;
  logic [NIOB:0] pad_in, pad_out_r, pad_oe_r, core_out, core_oe, exp_out, exp_oe;
  int fails, tests_run;
  int cap_n, shf_n, upd_n, cap_0, shf_0, upd_0;
  bst_row_t rows [8] = '{
    '{bst_pkg::IR_EXTEST, 5'h10, 1'b1, 4'h0, 2'h2},
    '{bst_pkg::IR_SAMPLE, 5'h0f, 1'b0, 4'h0, 2'h0},
    '{bst_pkg::IR_USER1,  5'h08, 1'b1, 4'h8, 2'h0},
    '{bst_pkg::IR_USER2,  5'h1b, 1'b0, 4'h4, 2'h0},
    '{bst_pkg::IR_RDBK,   5'h02, 1'b1, 4'h2, 2'h0},
    '{bst_pkg::IR_CFG,    5'h1e, 1'b0, 4'h1, 2'h1},
    '{bst_pkg::IR_RSVD,   5'h1f, 1'b0, 4'h0, 2'h0},
    '{bst_pkg::IR_BYPASS, 5'h1f, 1'b0, 4'h0, 2'h0}};

  // Output pin has a weak pull-up when not driven
  assign tdo_line = tdo_oe_r ? tdo_r : 1'b1;

  bst_port #(.NUM_IOB(NIOB)) bst_port_inst (
    .sys_clk, .rst_n, .cfg_busy, .scan_enable_symbol, .port_active_r,
    .tck, .tms, .tdi, .tdo_r, .tdo_oe_r, .pad_in, .mode_pin_zero, .mode_pin_two,
    .pad_out_r, .pad_oe_r, .core_out, .core_oe, .int_ts_in, .int_out_in,
    .update_internal_cell, .user_chain_one_out, .user_chain_two_out, .readback_data,
    .cfg_dout, .user_sel_one_r, .user_sel_two_r, .readback_sel_r, .cfg_sel_r,
    .dr_capture_r, .dr_shift_r, .dr_update_r);

  bst_tester bst_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line),
    .tdo_oe(tdo_oe_r));

  always #10 sys_clk = ~sys_clk;

  // Data-register strobes counted at each rising link clock edge
  always @(posedge tck) begin
    cap_n += dr_capture_r;
    shf_n += dr_shift_r;
    upd_n += dr_update_r;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic conclude;
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Pad bits of a boundary pattern, off = 3 for output cells, 4 for enables
  function automatic logic [NIOB:0] pick(input logic [31:0] p, input int off);
    for (int k = 0; k <= NIOB; k++) pick[k] = p[off + 3 * k];
  endfunction : pick

  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    sys_clk = 1'b0;
    {rst_n, cfg_busy, scan_enable_symbol} = 3'h0;
    {int_ts_in, user_chain_one_out, user_chain_two_out, readback_data, cfg_dout} = 5'h00;
    {mode_pin_zero, mode_pin_two, int_out_in} = 3'h5;
    pad_in = 9'h10b;
    core_out = 9'h1a5;
    core_oe = 9'h0f3;
    #2;
    fork
      step(6);
      bst_tester_inst.idle(12);
    join
    rst_n = 1'b1;
    cfg_busy = 1'b1;
    step(2);
    check(port_active_r === 1'b1, "port not active while configuring");
    bst_tester_inst.idle(5);
    // ---------------------------------------------------------
    // Every instruction code from the table
    // ---------------------------------------------------------
    foreach (rows[i]) begin
      {int_ts_in, user_chain_one_out, user_chain_two_out, readback_data, cfg_dout} = rows[i].src;
      bst_tester_inst.load_ir(rows[i].ir);
      check(bst_tester_inst.shifted[2:0] === 3'h1, "instruction capture");
      check({user_sel_one_r, user_sel_two_r, readback_sel_r, cfg_sel_r} === rows[i].sel,
        "path select");
      bst_tester_inst.scan_dr(PAT, BSR_LEN);
      check(bst_tester_inst.shifted[0] === rows[i].bit0, "tdo source");
      step(6);
      case (rows[i].pads)
        2'h0: {exp_out, exp_oe} = {core_out, core_oe};
        2'h1: {exp_out, exp_oe} = '0;
        default: {exp_out, exp_oe} = {pick(PAT, 3), pick(PAT, 4)};
      endcase
      check(pad_out_r === exp_out && pad_oe_r === exp_oe, "pad data source");
    end
    // ---------------------------------------------------------
    // Bypass length, capture value and output enable
    // ---------------------------------------------------------
    bst_tester_inst.load_ir(bst_pkg::IR_BYPASS);
    {cap_0, shf_0, upd_0} = {cap_n, shf_n, upd_n};
    bst_tester_inst.scan_dr(32'h5, 3);
    check(cap_n - cap_0 == 1 && shf_n - shf_0 == 3 && upd_n - upd_0 == 1,
      "data strobes");
    check(bst_tester_inst.shifted[2:0] === 3'h2, "bypass length");
    check(bst_tester_inst.oe_seen === 1'b1 && tdo_oe_r === 1'b0, "tdo enable");
    // ---------------------------------------------------------
    // Boundary cell order seen by a sample capture
    // ---------------------------------------------------------
    pad_in = 9'h0f4;
    {mode_pin_zero, mode_pin_two, int_out_in} = 3'h2;
    bst_tester_inst.load_ir(bst_pkg::IR_SAMPLE);
    bst_tester_inst.scan_dr(32'h0, BSR_LEN);
    check(bst_tester_inst.shifted[1] === int_out_in, "internal capture cell");
    check(bst_tester_inst.shifted[2] === pad_in[0], "first pad input cell");
    check(bst_tester_inst.shifted[26] === pad_in[NIOB], "output mode pin cell");
    check(bst_tester_inst.shifted[BSR_LEN-3] === mode_pin_zero &&
      bst_tester_inst.shifted[BSR_LEN-2] === mode_pin_two, "input mode pin cells");
    // ---------------------------------------------------------
    // Mode-select reset and deactivation
    // ---------------------------------------------------------
    bst_tester_inst.load_ir(bst_pkg::IR_USER1);
    bst_tester_inst.idle(6);
    check(user_sel_one_r === 1'b0, "mode-select reset");
    bst_tester_inst.load_ir(bst_pkg::IR_USER1);
    cfg_busy = 1'b0;
    step(2);
    check(port_active_r === 1'b0, "port still active");
    bst_tester_inst.idle(3);
    check(user_sel_one_r === 1'b0, "inactive port holds reset");
    scan_enable_symbol = 1'b1;
    step(2);
    check(port_active_r === 1'b1, "scan symbol keeps port");
    // ---------------------------------------------------------
    // Reset in mid-run while external test drives the pads
    // ---------------------------------------------------------
    bst_tester_inst.idle(3);
    bst_tester_inst.load_ir(bst_pkg::IR_EXTEST);
    bst_tester_inst.scan_dr(32'hffff_ffff, BSR_LEN);
    step(6);
    check(pad_oe_r === 9'h1ff, "extest enables");
    check(update_internal_cell === 1'b1, "update cell drive");
    rst_n = 1'b0;
    fork
      step(3);
      bst_tester_inst.idle(4);
    join
    check(pad_out_r === 9'h000 && pad_oe_r === 9'h000 && port_active_r === 1'b0,
      "reset state");
    conclude();
  end
endmodule : testbench
